//--- timer_pair_consts.svh
/*
 * Register indices, field positions, reset values and timing figures
 * of the timer pair and PWM channel block.
 * Assumes it is included by bare name; holds definitions only.
 */
`ifndef TIMER_PAIR_CONSTS_SVH
`define TIMER_PAIR_CONSTS_SVH

// ---------------------------------------------------------------
// Register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define IDX_WIDE_TIMER_CONTROL 6'h10
`define IDX_WIDE_TIMER_RELOAD_LOW 6'h11
`define IDX_WIDE_TIMER_RELOAD_HIGH 6'h12
`define IDX_WIDE_TIMER_COUNT_LOW 6'h13
`define IDX_WIDE_TIMER_COUNT_HIGH 6'h14
`define IDX_NARROW_TIMER_CONTROL 6'h15
`define IDX_PWM_CHANNEL_CONTROL 6'h16
`define IDX_NARROW_TIMER_RELOAD 6'h17
`define IDX_NARROW_TIMER_COUNT 6'h18
`define IDX_IRQ_STATUS 6'h19
`define IDX_IRQ_MASK 6'h1A

// ---------------------------------------------------------------
// Field positions and encodings
// ---------------------------------------------------------------
`define IRQ_BIT_WIDE 0
`define IRQ_BIT_NARROW 1
`define IRQ_BITS 2
`define PRESCALE_BITS 7
`define PULSE_RATE_BITS 4

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define RST_TIMER_CONTROL 8'h00
`define RST_PWM_CONTROL 6'h00
`define RST_RELOAD_BYTE 8'h00
`define RST_IRQ 2'h0

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define REF_CLK_PERIOD_NS 50
`define INTERNAL_RC_MHZ 4

`endif

//--- timer_pair_pkg.sv
/*
 * Types of the timer pair and PWM channel block.
 * Assumes the constants header is compiled alongside.
 */
package timer_pair_pkg;

	// Count clock source choices
	typedef enum logic [1:0] {
		SRC_EXT_PIN = 2'h0,
		SRC_OSC = 2'h1,
		SRC_INT_RC = 2'h2,
		SRC_UNUSED = 2'h3
	} clock_source_t;

	// Shared control byte layout of both timers
	typedef struct packed {
		logic enable;
		logic autoload_on_write;
		clock_source_t clock_source_sel;
		logic count_edge_sel;
		logic [2:0] prescale_sel;
	} timer_ctrl_t;

	// PWM control; the two unused positions are not stored
	typedef struct packed {
		logic pair_pwm_mode;
		logic pwm_initial_level;
		logic [3:0] pwm_irq_pulse_rate;
	} pwm_ctrl_t;

endpackage

//--- timer_pair_pwm_unit.sv
/*
 * Timer pair with PWM period logic: a 16-bit and an 8-bit up-counting
 * timer with reload, prescaler and source select, a PWM channel whose
 * period is the narrow timer, and an Avalon-MM register slave.
 * Assumes the partner duty timer lives outside and signals its
 * overflow on duty_overflow_in in this clock domain; count clocks
 * arrive asynchronously and are resynchronised here.
 */
// The Avalon-MM register port was left to the implementer.
// Summary of operation
// - Sixteen-bit up counter with two reload bytes
// - Timers count only while enabled; gates PWM
// - Auto-load copies written reload into counter
// - Auto-load acts only on reload writes
// - Wrap always reloads counter from reload register
// - Two-bit source: pin, oscillator, internal RC
// - Edge select applies to count pin only
// - Prescaler divides by two to the field
// - Eight-bit up counter with one reload
// - Narrow timer has same control layout
// - Narrow timer sets PWM period, partner duty
// - Mode bit selects independent timers or PWM
// - Initial level bit sets PWM start polarity
// - PWM event every rate-plus-one completed pulses
// - Count registers read-only, status write-one-to-clear, others read-write
// - PWM control bits five, four hold nothing
`timescale 1ns/1ns
`include "timer_pair_consts.svh"

// ---------------------------------------------------------------
// One timer channel: edge detect, prescaler, counter
// ---------------------------------------------------------------
module timer_core #(
	parameter int WIDTH = 16
) (
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	input wire timer_pair_pkg::timer_ctrl_t ctrl_in,
	input wire logic ext_level_in,
	input wire logic osc_level_in,
	input wire logic rc_level_in,
	input wire logic [WIDTH-1:0] reload_in,
	input wire logic [WIDTH-1:0] load_mask_in,
	output logic [WIDTH-1:0] count_out,
	output logic wrap_out
);
	logic ext_prev_reg;
	logic osc_prev_reg;
	logic rc_prev_reg;
	logic [`PRESCALE_BITS-1:0] presc_reg;
	logic [`PRESCALE_BITS-1:0] presc_next;
	logic [WIDTH-1:0] count_reg;
	logic [WIDTH-1:0] count_next;
	logic wrap_reg;

	// Edges of the already synchronised levels
	wire ext_rise = ext_level_in & ~ext_prev_reg;
	wire ext_fall = ~ext_level_in & ext_prev_reg;
	wire ext_edge = ctrl_in.count_edge_sel ? ext_fall : ext_rise;
	wire osc_rise = osc_level_in & ~osc_prev_reg;
	wire rc_rise = rc_level_in & ~rc_prev_reg;

	// Source select; the unused code gives no ticks at all, so a timer
	// left on that code simply stands still rather than counting noise
	wire src_tick = (ctrl_in.clock_source_sel == timer_pair_pkg::SRC_EXT_PIN) ? ext_edge :
		(ctrl_in.clock_source_sel == timer_pair_pkg::SRC_OSC) ? osc_rise :
		(ctrl_in.clock_source_sel == timer_pair_pkg::SRC_INT_RC) ? rc_rise :
		1'b0;

	// Divide by two to the field: pass when the low field bits are all ones
	wire [7:0] presc_span = 8'h01 << ctrl_in.prescale_sel;
	wire [7:0] presc_span_m1 = presc_span - 8'h01;
	wire [`PRESCALE_BITS-1:0] presc_mask = presc_span_m1[`PRESCALE_BITS-1:0];
	wire presc_tick = src_tick & ((presc_reg & presc_mask) == presc_mask);
	wire count_tick = ctrl_in.enable & presc_tick;
	wire at_top = &count_reg;
	wire [WIDTH-1:0] count_inc = count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
	wire [WIDTH-1:0] count_run = count_tick ? (at_top ? reload_in : count_inc) : count_reg;

	// Prescaler is cleared while halted so a restart begins a full division
	assign presc_next = !ctrl_in.enable ? {`PRESCALE_BITS{1'b0}} :
		src_tick ? presc_reg + {{(`PRESCALE_BITS-1){1'b0}}, 1'b1} : presc_reg;
	// A reload write with auto-load wins over a count in the same cycle
	assign count_next = (count_run & ~load_mask_in) | (reload_in & load_mask_in);
	assign count_out = count_reg;
	assign wrap_out = wrap_reg;

	// Edge history of the source levels
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ext_prev_reg <= 1'b0;
			osc_prev_reg <= 1'b0;
			rc_prev_reg <= 1'b0;
		end else begin
			ext_prev_reg <= ext_level_in;
			osc_prev_reg <= osc_level_in;
			rc_prev_reg <= rc_level_in;
		end
	end

	// Prescaler, counter and overflow pulse. The wrap pulse is registered,
	// so it comes one cycle after the wrapping tick, with the reloaded count; interrupt and PWM logic both
	// allow for that lag.
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			presc_reg <= {`PRESCALE_BITS{1'b0}};
			count_reg <= {WIDTH{1'b0}};
			wrap_reg <= 1'b0;
		end else begin
			presc_reg <= presc_next;
			count_reg <= count_next;
			wrap_reg <= count_tick & at_top;
		end
	end
endmodule

// ---------------------------------------------------------------
// Top: register slave, two timers, PWM channel, interrupt
// ---------------------------------------------------------------
module timer_pair_pwm_unit #(
	parameter int WIDE_WIDTH = 16,
	parameter int NARROW_WIDTH = 8
) (
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	input wire logic [7:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	input wire logic external_count_pin_in,
	input wire logic crystal_osc_input_in,
	input wire logic external_rc_clock_in,
	input wire logic dual_rc_mode_in,
	input wire logic internal_rc_clock_in,
	input wire logic duty_overflow_in,
	output logic pwm_out,
	output logic pwm_period_start_out,
	output logic irq_out
);
	logic [3:0] sync1_reg;
	logic [3:0] sync2_reg;
	logic wait_reg;
	logic [31:0] readdata_reg;
	timer_pair_pkg::timer_ctrl_t wide_ctrl_reg;
	timer_pair_pkg::timer_ctrl_t narrow_ctrl_reg;
	timer_pair_pkg::pwm_ctrl_t pwm_ctrl_reg;
	logic [WIDE_WIDTH-1:0] wide_reload_reg;
	logic [WIDE_WIDTH-1:0] wide_reload_next;
	logic [NARROW_WIDTH-1:0] narrow_reload_reg;
	logic [NARROW_WIDTH-1:0] narrow_reload_next;
	logic [`IRQ_BITS-1:0] irq_status_reg;
	logic [`IRQ_BITS-1:0] irq_status_next;
	logic [`IRQ_BITS-1:0] irq_mask_reg;
	logic irq_reg;
	logic pwm_level_reg;
	logic pwm_level_next;
	logic pwm_out_reg;
	logic period_start_reg;
	logic [`PULSE_RATE_BITS-1:0] pulse_cnt_reg;
	logic [`PULSE_RATE_BITS-1:0] pulse_cnt_next;
	logic pwm_event_reg;
	logic [WIDE_WIDTH-1:0] wide_count;
	logic [NARROW_WIDTH-1:0] narrow_count;
	logic wide_wrap;
	logic narrow_wrap;

	// Two-stage synchronisers for count pin, crystal, external RC and
	// internal RC; every count clock is foreign to this domain
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sync1_reg <= 4'h0;
			sync2_reg <= 4'h0;
		end else begin
			sync1_reg <= {internal_rc_clock_in, external_rc_clock_in, crystal_osc_input_in,
				external_count_pin_in};
			sync2_reg <= sync1_reg;
		end
	end

	// Source for code 01 is the crystal input or the external RC clock,
	// chosen after the synchronisers; flipping the choice while the two
	// levels differ can fake one edge, so switch it with the timers halted
	wire osc_level = dual_rc_mode_in ? sync2_reg[2] : sync2_reg[1];

	// Bus decode: one answer cycle after the request is seen
	wire bus_req = avs_read_in | avs_write_in;
	wire addr_aligned = (avs_address_in[1:0] == 2'h0);
	wire [5:0] reg_idx = avs_address_in[7:2];
	wire wr_ok = avs_write_in & ~wait_reg & addr_aligned & avs_byteenable_in[0];
	wire [7:0] wr_byte = avs_writedata_in[7:0];
	// Count indices have no write strobe, so writes there are dropped
	wire wr_wide_ctrl = wr_ok & (reg_idx == `IDX_WIDE_TIMER_CONTROL);
	wire wr_wide_lo = wr_ok & (reg_idx == `IDX_WIDE_TIMER_RELOAD_LOW);
	wire wr_wide_hi = wr_ok & (reg_idx == `IDX_WIDE_TIMER_RELOAD_HIGH);
	wire wr_narrow_ctrl = wr_ok & (reg_idx == `IDX_NARROW_TIMER_CONTROL);
	wire wr_pwm_ctrl = wr_ok & (reg_idx == `IDX_PWM_CHANNEL_CONTROL);
	wire wr_narrow_rl = wr_ok & (reg_idx == `IDX_NARROW_TIMER_RELOAD);
	wire wr_irq_status = wr_ok & (reg_idx == `IDX_IRQ_STATUS);
	wire wr_irq_mask = wr_ok & (reg_idx == `IDX_IRQ_MASK);

	// Read mux; unmapped or misaligned addresses read as zero. The count
	// bytes of the wide timer have no snapshot latch, so software that
	// needs a coherent pair must read high, low, high and retry on a carry.
	wire [7:0] pwm_ctrl_byte = {pwm_ctrl_reg.pair_pwm_mode, pwm_ctrl_reg.pwm_initial_level,
		2'h0, pwm_ctrl_reg.pwm_irq_pulse_rate};
	wire [7:0] rd_byte = !addr_aligned ? 8'h00 :
		(reg_idx == `IDX_WIDE_TIMER_CONTROL) ? wide_ctrl_reg :
		(reg_idx == `IDX_WIDE_TIMER_RELOAD_LOW) ? wide_reload_reg[7:0] :
		(reg_idx == `IDX_WIDE_TIMER_RELOAD_HIGH) ? wide_reload_reg[15:8] :
		(reg_idx == `IDX_WIDE_TIMER_COUNT_LOW) ? wide_count[7:0] :
		(reg_idx == `IDX_WIDE_TIMER_COUNT_HIGH) ? wide_count[15:8] :
		(reg_idx == `IDX_NARROW_TIMER_CONTROL) ? narrow_ctrl_reg :
		(reg_idx == `IDX_PWM_CHANNEL_CONTROL) ? pwm_ctrl_byte :
		(reg_idx == `IDX_NARROW_TIMER_RELOAD) ? narrow_reload_reg :
		(reg_idx == `IDX_NARROW_TIMER_COUNT) ? narrow_count :
		(reg_idx == `IDX_IRQ_STATUS) ? {6'h00, irq_status_reg} :
		(reg_idx == `IDX_IRQ_MASK) ? {6'h00, irq_mask_reg} :
		8'h00;

	// Slave handshake: wait_reg idles high, drops for the answer cycle.
	// A fixed single wait state keeps the read mux off the bus path at
	// the cost of two cycles per access.
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wait_reg <= 1'b1;
			readdata_reg <= 32'h0000_0000;
		end else begin
			wait_reg <= ~(bus_req & wait_reg);
			if (avs_read_in & wait_reg) begin
				readdata_reg <= {24'h00_0000, rd_byte};
			end
		end
	end

	// New reload values; the counter sees them in the write cycle,
	// so a wrap in that very cycle already reloads the new byte
	assign wide_reload_next = {wr_wide_hi ? wr_byte : wide_reload_reg[15:8],
		wr_wide_lo ? wr_byte : wide_reload_reg[7:0]};
	assign narrow_reload_next = wr_narrow_rl ? wr_byte : narrow_reload_reg;

	// Auto-load masks, live only in the cycle the reload byte is written
	wire [WIDE_WIDTH-1:0] wide_load_mask = {{8{wr_wide_hi & wide_ctrl_reg.autoload_on_write}},
		{8{wr_wide_lo & wide_ctrl_reg.autoload_on_write}}};
	wire [NARROW_WIDTH-1:0] narrow_load_mask =
		{NARROW_WIDTH{wr_narrow_rl & narrow_ctrl_reg.autoload_on_write}};

	// Control and reload registers. Auto-load reads the control bit as it
	// stands, so a control write and a reload write are two accesses.
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wide_ctrl_reg <= `RST_TIMER_CONTROL;
			narrow_ctrl_reg <= `RST_TIMER_CONTROL;
			pwm_ctrl_reg <= `RST_PWM_CONTROL;
			wide_reload_reg <= {`RST_RELOAD_BYTE, `RST_RELOAD_BYTE};
			narrow_reload_reg <= `RST_RELOAD_BYTE;
			irq_mask_reg <= `RST_IRQ;
		end else begin
			wide_reload_reg <= wide_reload_next;
			narrow_reload_reg <= narrow_reload_next;
			if (wr_wide_ctrl) begin
				wide_ctrl_reg <= wr_byte;
			end
			if (wr_narrow_ctrl) begin
				narrow_ctrl_reg <= wr_byte;
			end
			if (wr_pwm_ctrl) begin
				pwm_ctrl_reg <= {wr_byte[7:6], wr_byte[3:0]};
			end
			if (wr_irq_mask) begin
				irq_mask_reg <= wr_byte[`IRQ_BITS-1:0];
			end
		end
	end

	// Wide timer instance
	timer_core #(
		.WIDTH(WIDE_WIDTH)
	) u_wide_timer (
		.ref_clk_in(ref_clk_in),
		.rst_b_in(rst_b_in),
		.ctrl_in(wide_ctrl_reg),
		.ext_level_in(sync2_reg[0]),
		.osc_level_in(osc_level),
		.rc_level_in(sync2_reg[3]),
		.reload_in(wide_reload_next),
		.load_mask_in(wide_load_mask),
		.count_out(wide_count),
		.wrap_out(wide_wrap)
	);

	// Narrow timer instance, the PWM period source in paired mode
	timer_core #(
		.WIDTH(NARROW_WIDTH)
	) u_narrow_timer (
		.ref_clk_in(ref_clk_in),
		.rst_b_in(rst_b_in),
		.ctrl_in(narrow_ctrl_reg),
		.ext_level_in(sync2_reg[0]),
		.osc_level_in(osc_level),
		.rc_level_in(sync2_reg[3]),
		.reload_in(narrow_reload_next),
		.load_mask_in(narrow_load_mask),
		.count_out(narrow_count),
		.wrap_out(narrow_wrap)
	);

	// PWM active only when paired and the narrow timer is enabled; the
	// duty timer's own enable is the partner's business and not seen here
	wire pwm_active = pwm_ctrl_reg.pair_pwm_mode & narrow_ctrl_reg.enable;
	wire start_level = ~pwm_ctrl_reg.pwm_initial_level;
	wire pulse_done = pwm_active & narrow_wrap;
	wire rate_hit = (pulse_cnt_reg == pwm_ctrl_reg.pwm_irq_pulse_rate);

	// Period end restarts the level; it outranks a coincident duty overflow
	assign pwm_level_next = !pwm_active ? start_level :
		pulse_done ? start_level :
		duty_overflow_in ? pwm_ctrl_reg.pwm_initial_level :
		pwm_level_reg;
	// Completed pulses counted modulo rate plus one
	assign pulse_cnt_next = !pwm_active ? {`PULSE_RATE_BITS{1'b0}} :
		!pulse_done ? pulse_cnt_reg :
		rate_hit ? {`PULSE_RATE_BITS{1'b0}} :
		pulse_cnt_reg + {{(`PULSE_RATE_BITS-1){1'b0}}, 1'b1};

	// PWM level, pulse counter and event pulse. A duty overflow that
	// arrives while the channel is idle is ignored; the level only leaves
	// its start value once a period is running.
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pwm_level_reg <= 1'b1;
			pwm_out_reg <= 1'b0;
			period_start_reg <= 1'b0;
			pulse_cnt_reg <= {`PULSE_RATE_BITS{1'b0}};
			pwm_event_reg <= 1'b0;
		end else begin
			pwm_level_reg <= pwm_level_next;
			pwm_out_reg <= pwm_active & pwm_level_next;
			period_start_reg <= pulse_done;
			pulse_cnt_reg <= pulse_cnt_next;
			pwm_event_reg <= pulse_done & rate_hit;
		end
	end

	// Interrupt events; paired mode swaps the narrow wrap for the pulse event
	wire narrow_event = pwm_ctrl_reg.pair_pwm_mode ? pwm_event_reg : narrow_wrap;
	wire [`IRQ_BITS-1:0] irq_events = {narrow_event, wide_wrap};
	wire [`IRQ_BITS-1:0] irq_clear = wr_irq_status ? wr_byte[`IRQ_BITS-1:0] : `RST_IRQ;
	// A new event beats a write-one clear in the same cycle
	assign irq_status_next = (irq_status_reg & ~irq_clear) | irq_events;

	// Sticky status and masked interrupt level. irq_out follows the status
	// one cycle late, so a handler that clears and exits at once may see
	// the line high for one more cycle.
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			irq_status_reg <= `RST_IRQ;
			irq_reg <= 1'b0;
		end else begin
			irq_status_reg <= irq_status_next;
			irq_reg <= |(irq_status_reg & irq_mask_reg);
		end
	end

	// Outputs straight from flip-flops
	assign avs_readdata_out = readdata_reg;
	assign avs_waitrequest_out = wait_reg;
	assign pwm_out = pwm_out_reg;
	assign pwm_period_start_out = period_start_reg;
	assign irq_out = irq_reg;
endmodule

//--- timer_pair_pwm_unit_sva.sv
/*
 * Port checker of the timer pair unit: register bus answers and the
 * causes of PWM and interrupt output changes.
 * Assumes a bind to the top module and a single clock domain.
 */
`timescale 1ns/1ns

// ----------
// Checker
// ----------
module timer_pair_chk (
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	input wire logic [7:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_readdata_out,
	input wire logic avs_waitrequest_out,
	input wire logic duty_overflow_in,
	input wire logic pwm_out,
	input wire logic pwm_period_start_out,
	input wire logic irq_out
);
	default clocking @(posedge ref_clk_in);
	endclocking
	default disable iff (!rst_b_in);

	// Steps of one bus access
	sequence req_taken;
		(avs_read_in || avs_write_in) && avs_waitrequest_out;
	endsequence
	sequence answered;
		!avs_waitrequest_out;
	endsequence

	// Read answer decode
	wire logic rd_ans = avs_read_in && !avs_waitrequest_out;
	wire logic [5:0] reg_idx = avs_address_in[7:2];

	bus_answer_a: assert property (req_taken |=> answered ##1 avs_waitrequest_out)
		else $error("bus answer not exactly one wait cycle");
	idle_quiet_a: assert property (!(avs_read_in || avs_write_in) && avs_waitrequest_out
		|=> avs_waitrequest_out)
		else $error("waitrequest dropped with no request");
	rdata_upper_a: assert property (rd_ans |-> avs_readdata_out[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	rdata_hold_a: assert property (!(avs_read_in && avs_waitrequest_out)
		|=> $stable(avs_readdata_out))
		else $error("read data moved without a read");
	misalign_zero_a: assert property (rd_ans && avs_address_in[1:0] != 2'h0
		|-> avs_readdata_out == 32'h0)
		else $error("misaligned read not zero");
	unmapped_zero_a: assert property (rd_ans && (reg_idx < 6'h10 || reg_idx > 6'h1A)
		|-> avs_readdata_out == 32'h0)
		else $error("unmapped read not zero");
	// A level change needs a duty overflow, a period end or a control write
	pwm_cause_a: assert property ($changed(pwm_out) |-> ($past(duty_overflow_in)
		|| $past(duty_overflow_in, 2) || $past(avs_write_in) || $past(avs_write_in, 2)
		|| $past(pwm_period_start_out)) or ##[0:1] pwm_period_start_out)
		else $error("pwm level changed without cause");
	irq_clear_a: assert property ($fell(irq_out) |-> $past(avs_write_in)
		|| $past(avs_write_in, 2))
		else $error("interrupt dropped without a write");
endmodule

bind timer_pair_pwm_unit timer_pair_chk i_timer_pair_chk (
	.ref_clk_in(ref_clk_in),
	.rst_b_in(rst_b_in),
	.avs_address_in(avs_address_in),
	.avs_read_in(avs_read_in),
	.avs_write_in(avs_write_in),
	.avs_readdata_out(avs_readdata_out),
	.avs_waitrequest_out(avs_waitrequest_out),
	.duty_overflow_in(duty_overflow_in),
	.pwm_out(pwm_out),
	.pwm_period_start_out(pwm_period_start_out),
	.irq_out(irq_out)
);

//--- tb.sv
/*
 * Self-checking bench of the timer pair unit: registers, counting,
 * wrap, interrupt and PWM tests through Avalon bus tasks.
 * Assumes the slave answers on its own waitrequest; one clock.
 */
`timescale 1ns/1ns

module tb;
	logic ref_clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic [7:0] adr = 8'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdat = 32'h0;
	logic [3:0] ben = 4'hF;
	logic pin = 1'b0;
	logic rc = 1'b0;
	logic osc = 1'b0;
	logic xrc = 1'b0;
	logic dual = 1'b0;
	logic duty = 1'b0;
	logic [31:0] rdat;
	logic wait_req;
	logic pwm;
	logic start;
	logic irq;
	logic [31:0] got;
	int n_fail = 0;
	int checks_done = 0;
	int n_starts = 0;
	int ps_t[5] = '{0, 0, 1, 2, 7};
	int eg_t[5] = '{0, 1, 0, 0, 0};
	int k_t[5] = '{5, 5, 5, 9, 130};

	// ----------
	// Clocks and device
	// ----------
	always #25 ref_clk_in = ~ref_clk_in;
	always @(posedge ref_clk_in) if (start === 1'b1) n_starts++;

	timer_pair_pwm_unit i_timer_pair_pwm_unit (
		.ref_clk_in(ref_clk_in),
		.rst_b_in(rst_b_in),
		.avs_address_in(adr),
		.avs_read_in(rd),
		.avs_write_in(wr),
		.avs_writedata_in(wdat),
		.avs_byteenable_in(ben),
		.avs_readdata_out(rdat),
		.avs_waitrequest_out(wait_req),
		.external_count_pin_in(pin),
		.crystal_osc_input_in(osc),
		.external_rc_clock_in(xrc),
		.dual_rc_mode_in(dual),
		.internal_rc_clock_in(rc),
		.duty_overflow_in(duty),
		.pwm_out(pwm),
		.pwm_period_start_out(start),
		.irq_out(irq)
	);

	// ----------
	// Tasks
	// ----------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Request held until waitrequest is sampled low
	task automatic access(input logic [7:0] a, input logic w, input logic [7:0] d);
		@(posedge ref_clk_in);
		adr <= a;
		wdat <= {24'h0, d};
		rd <= ~w;
		wr <= w;
		do begin
			@(posedge ref_clk_in);
		end while (wait_req !== 1'b0);
		got = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic wreg(input logic [5:0] i, input logic [7:0] d);
		access({i, 2'h0}, 1'b1, d);
	endtask
	task automatic rchk(input logic [5:0] i, input logic [7:0] e);
		access({i, 2'h0}, 1'b0, 8'h00);
		check(got, {24'h0, e});
	endtask
	// Count lines toggle four cycles apart, then resync settles; m picks
	// the lines: bit 0 pin, 1 crystal, 2 external RC, 3 internal RC
	task automatic pin_edges(input int n, input logic [3:0] m = 4'h1);
		repeat (n) begin
			@(posedge ref_clk_in);
			pin <= pin ^ m[0];
			osc <= osc ^ m[1];
			xrc <= xrc ^ m[2];
			rc <= rc ^ m[3];
			repeat (3) @(posedge ref_clk_in);
		end
		repeat (5) @(posedge ref_clk_in);
	endtask
	task automatic duty_pulse;
		@(posedge ref_clk_in);
		duty <= 1'b1;
		@(posedge ref_clk_in);
		duty <= 1'b0;
		repeat (3) @(posedge ref_clk_in);
	endtask
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Watchdog far beyond the few thousand cycles the tests need
	initial begin
		#1000000;
		n_fail++;
		close_out();
	end

	// ----------
	// Tests
	// ----------
	initial begin
		repeat (6) @(posedge ref_clk_in);
		rst_b_in <= 1'b1;
		for (int i = 16; i <= 26; i++) rchk(i[5:0], 8'h00);
		rchk(6'h08, 8'h00);
		access(8'h41, 1'b0, 8'h00);
		check(got, 32'h0);
		done("reset");
		wreg(6'h10, 8'h6F);
		rchk(6'h10, 8'h6F);
		wreg(6'h11, 8'hA5);
		wreg(6'h12, 8'h5A);
		rchk(6'h12, 8'h5A);
		rchk(6'h13, 8'hA5);
		rchk(6'h14, 8'h5A);
		wreg(6'h13, 8'hFF);
		rchk(6'h13, 8'hA5);
		wreg(6'h15, 8'h6F);
		rchk(6'h15, 8'h6F);
		wreg(6'h16, 8'hFF);
		rchk(6'h16, 8'hCF);
		wreg(6'h17, 8'h3C);
		rchk(6'h18, 8'h3C);
		ben <= 4'hE;
		wreg(6'h17, 8'h11);
		ben <= 4'hF;
		rchk(6'h17, 8'h3C);
		wreg(6'h1A, 8'h03);
		rchk(6'h1A, 8'h03);
		wreg(6'h1A, 8'h00);
		wreg(6'h10, 8'h00);
		wreg(6'h11, 8'h11);
		rchk(6'h13, 8'hA5);
		done("registers");
		for (int j = 0; j < 5; j++) begin
			wreg(6'h10, 8'h40);
			if (pin) pin_edges(1);
			wreg(6'h11, 8'hF0);
			wreg(6'h10, {1'b1, 3'h0, eg_t[j][0], ps_t[j][2:0]});
			pin_edges(2 * k_t[j] - eg_t[j]);
			rchk(6'h13, 8'hF0 + 8'((k_t[j] - eg_t[j]) >> ps_t[j]));
		end
		wreg(6'h10, 8'h00);
		pin_edges(4);
		rchk(6'h13, 8'hF1);
		done("prescale");
		wreg(6'h10, 8'h40);
		wreg(6'h11, 8'h00);
		wreg(6'h10, 8'h98);
		pin_edges(4, 4'hD);
		rchk(6'h13, 8'h00);
		pin_edges(4, 4'h2);
		rchk(6'h13, 8'h02);
		dual <= 1'b1;
		pin_edges(4, 4'h2);
		pin_edges(4, 4'h4);
		rchk(6'h13, 8'h04);
		wreg(6'h10, 8'hA0);
		pin_edges(4, 4'h8);
		rchk(6'h13, 8'h06);
		wreg(6'h10, 8'h00);
		dual <= 1'b0;
		done("sources");
		wreg(6'h10, 8'h40);
		wreg(6'h11, 8'hFE);
		wreg(6'h12, 8'hFF);
		wreg(6'h10, 8'h00);
		wreg(6'h11, 8'h20);
		rchk(6'h13, 8'hFE);
		wreg(6'h19, 8'h03);
		wreg(6'h10, 8'h80);
		pin_edges(6);
		wreg(6'h10, 8'h00);
		rchk(6'h13, 8'h21);
		rchk(6'h14, 8'hFF);
		rchk(6'h19, 8'h01);
		check(irq, 32'h0);
		wreg(6'h1A, 8'h01);
		repeat (2) @(posedge ref_clk_in);
		check(irq, 32'h1);
		wreg(6'h19, 8'h01);
		repeat (2) @(posedge ref_clk_in);
		check(irq, 32'h0);
		done("wrap");
		wreg(6'h15, 8'h40);
		wreg(6'h17, 8'hFE);
		wreg(6'h16, 8'h81);
		wreg(6'h1A, 8'h02);
		wreg(6'h15, 8'h80);
		repeat (2) @(posedge ref_clk_in);
		check(pwm, 32'h1);
		duty_pulse();
		check(pwm, 32'h0);
		n_starts = 0;
		pin_edges(4);
		check(pwm, 32'h1);
		rchk(6'h19, 8'h00);
		pin_edges(4);
		rchk(6'h19, 8'h02);
		check(irq, 32'h1);
		check(n_starts, 32'h2);
		wreg(6'h15, 8'h00);
		repeat (2) @(posedge ref_clk_in);
		check(pwm, 32'h0);
		wreg(6'h16, 8'hC1);
		wreg(6'h15, 8'h80);
		repeat (2) @(posedge ref_clk_in);
		check(pwm, 32'h0);
		duty_pulse();
		check(pwm, 32'h1);
		done("pwm");
		wreg(6'h15, 8'h00);
		wreg(6'h16, 8'h00);
		wreg(6'h19, 8'h03);
		wreg(6'h15, 8'h80);
		n_starts = 0;
		pin_edges(4);
		rchk(6'h19, 8'h02);
		check(pwm, 32'h0);
		check(n_starts, 32'h0);
		done("timer mode");
		close_out();
	end
endmodule
